// file: logic/caf_pkg.sv
package caf_pkg;

	// Sizes
	localparam int unsigned NUM_FILTERS = 16;
	localparam int unsigned NUM_MASKS   = 4;
	localparam int unsigned NUM_CTL     = 4;
	localparam int unsigned ID_W        = 11;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned IDX_W       = 4;

	// Register map, byte addresses
	localparam logic [7:0] CTL_BASE    = 8'h00;
	localparam logic [7:0] MASK_BASE   = 8'h10;
	localparam logic [7:0] FID_BASE    = 8'h20;
	localparam logic [7:0] STATUS_ADDR = 8'h60;

	// Control byte layout
	localparam int unsigned EN_BIT       = 7;
	localparam int unsigned MSEL_LO      = 5;
	localparam int unsigned MSEL_W       = 2;
	localparam int unsigned FSEL_LO      = 0;
	localparam int unsigned FSEL_W       = 5;
	localparam int unsigned FSEL_RSV_BIT = 4;

	// Status layout
	localparam int unsigned ST_FIFO_LO   = 0;
	localparam int unsigned ST_FILT_LO   = 4;
	localparam int unsigned ST_SEEN_BIT  = 8;
	localparam int unsigned ST_COUNT_LO  = 16;

	// Reset values
	localparam logic [7:0]      CTL_BYTE_RESET = 8'h00;
	localparam logic [ID_W-1:0] MASK_RESET     = 11'h000;
	localparam logic [ID_W-1:0] FID_RESET      = 11'h000;

	// Aligned word inside a block of count words at base
	function automatic logic word_hit(input logic [ADDR_W-1:0] addr,
	                                  input logic [ADDR_W-1:0] base,
	                                  input int unsigned       count);
		logic [ADDR_W-1:0] off;
		off = addr - base;
		word_hit = (addr >= base) && (off[1:0] == 2'b00) && (int'(off[ADDR_W-1:2]) < count);
	endfunction

	function automatic logic [ADDR_W-3:0] word_idx(input logic [ADDR_W-1:0] addr,
	                                               input logic [ADDR_W-1:0] base);
		logic [ADDR_W-1:0] off;
		off = addr - base;
		word_idx = off[ADDR_W-1:2];
	endfunction

	// Enabled filter keeps its fields; only the enable bit may change
	function automatic logic [7:0] ctl_byte_update(input logic [7:0] old_byte,
	                                               input logic [7:0] new_byte);
		if (old_byte[EN_BIT]) begin
			ctl_byte_update = {new_byte[EN_BIT], old_byte[EN_BIT-1:0]};
		end else begin
			ctl_byte_update = new_byte;
		end
	endfunction

endpackage

// file: logic/caf_match.sv
`timescale 1ns/1ps
module caf_match (
	// Filter setup
	input  wire logic [caf_pkg::NUM_FILTERS-1:0][7:0]             ctl_in,
	input  wire logic [caf_pkg::NUM_MASKS-1:0][caf_pkg::ID_W-1:0]  mask_in,
	input  wire logic [caf_pkg::NUM_FILTERS-1:0][caf_pkg::ID_W-1:0] fid_in,
	// Identifier under test
	input  wire logic [caf_pkg::ID_W-1:0]                          id_in,
	// Result
	output logic                                                   hit_out,
	output logic [caf_pkg::IDX_W-1:0]                              filter_out,
	output logic [caf_pkg::IDX_W-1:0]                              fifo_out
);

	logic [caf_pkg::MSEL_W-1:0] sel;
	logic [caf_pkg::FSEL_W-1:0] dest;
	logic [caf_pkg::ID_W-1:0]   m;

	// Descending scan so the lowest numbered filter wins
	always_comb begin
		sel        = '0;
		dest       = '0;
		m          = '0;
		hit_out    = 1'b0;
		filter_out = '0;
		fifo_out   = '0;
		for (int i = caf_pkg::NUM_FILTERS - 1; i >= 0; i--) begin
			sel  = ctl_in[i][caf_pkg::MSEL_LO +: caf_pkg::MSEL_W];
			dest = ctl_in[i][caf_pkg::FSEL_LO +: caf_pkg::FSEL_W];
			m    = mask_in[sel];
			if (ctl_in[i][caf_pkg::EN_BIT] && !dest[caf_pkg::FSEL_RSV_BIT] &&
			    (((id_in ^ fid_in[i]) & m) == '0)) begin
				hit_out    = 1'b1;
				filter_out = caf_pkg::IDX_W'(i);
				fifo_out   = dest[caf_pkg::IDX_W-1:0];
			end
		end
	end

endmodule

// file: logic/caf_filter_config.sv
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module caf_filter_config (
	// Clock and reset
	input  wire logic                         mclk_in,
	input  wire logic                         resetn_in,
	// Register port
	input  wire logic [caf_pkg::ADDR_W-1:0]   addr_in,
	input  wire logic [caf_pkg::DATA_W-1:0]   wdata_in,
	input  wire logic                         wr_in,
	input  wire logic                         rd_in,
	output logic      [caf_pkg::DATA_W-1:0]   rdata_out,
	// Received identifier
	input  wire logic                         rx_valid_in,
	input  wire logic [caf_pkg::ID_W-1:0]     rx_id_in,
	// Store request towards the FIFOs
	output logic                              store_valid_out,
	output logic      [caf_pkg::IDX_W-1:0]    store_fifo_out,
	output logic      [caf_pkg::IDX_W-1:0]    store_filter_out,
	// Filter enables
	output logic      [caf_pkg::NUM_FILTERS-1:0] filter_enable_out
);

	typedef struct packed {
		logic [caf_pkg::NUM_FILTERS-1:0][7:0]              ctl;
		logic [caf_pkg::NUM_MASKS-1:0][caf_pkg::ID_W-1:0]   mask;
		logic [caf_pkg::NUM_FILTERS-1:0][caf_pkg::ID_W-1:0] fid;
		logic [caf_pkg::DATA_W-1:0]                         rdata;
		logic                                               hit;
		logic [caf_pkg::IDX_W-1:0]                          hit_filter;
		logic [caf_pkg::IDX_W-1:0]                          hit_fifo;
		logic                                               seen;
		logic [15:0]                                        hit_count;
		logic [caf_pkg::NUM_FILTERS-1:0]                    en;
	} caf_state_s;

	caf_state_s q;
	caf_state_s d;

	logic                       m_hit;
	logic [caf_pkg::IDX_W-1:0]  m_filter;
	logic [caf_pkg::IDX_W-1:0]  m_fifo;
	logic [caf_pkg::ADDR_W-3:0] widx;
	logic [caf_pkg::IDX_W-1:0]  fidx;
	logic [7:0]                 upd;

	caf_match u_match (
		.ctl_in     (q.ctl),
		.mask_in    (q.mask),
		.fid_in     (q.fid),
		.id_in      (rx_id_in),
		.hit_out    (m_hit),
		.filter_out (m_filter),
		.fifo_out   (m_fifo)
	);

	always_comb begin
		d    = q;
		widx = '0;
		fidx = '0;
		upd  = '0;

		// Register writes
		if (wr_in) begin
			if (caf_pkg::word_hit(addr_in, caf_pkg::CTL_BASE, caf_pkg::NUM_CTL)) begin
				widx = caf_pkg::word_idx(addr_in, caf_pkg::CTL_BASE);
				for (int j = 0; j < 4; j++) begin
					fidx = {widx[1:0], 2'(j)};
					upd  = caf_pkg::ctl_byte_update(q.ctl[fidx], wdata_in[8*j +: 8]);
					d.ctl[fidx] = upd;
				end
			end else if (caf_pkg::word_hit(addr_in, caf_pkg::MASK_BASE,
			                               caf_pkg::NUM_MASKS)) begin
				widx = caf_pkg::word_idx(addr_in, caf_pkg::MASK_BASE);
				d.mask[widx[1:0]] = wdata_in[caf_pkg::ID_W-1:0];
			end else if (caf_pkg::word_hit(addr_in, caf_pkg::FID_BASE,
			                               caf_pkg::NUM_FILTERS)) begin
				widx = caf_pkg::word_idx(addr_in, caf_pkg::FID_BASE);
				d.fid[widx[caf_pkg::IDX_W-1:0]] = wdata_in[caf_pkg::ID_W-1:0];
			end
		end

		// Register reads, data in the next cycle only
		d.rdata = '0;
		if (rd_in) begin
			if (caf_pkg::word_hit(addr_in, caf_pkg::CTL_BASE, caf_pkg::NUM_CTL)) begin
				widx = caf_pkg::word_idx(addr_in, caf_pkg::CTL_BASE);
				d.rdata = q.ctl[{widx[1:0], 2'b00} +: 4];
			end else if (caf_pkg::word_hit(addr_in, caf_pkg::MASK_BASE,
			                               caf_pkg::NUM_MASKS)) begin
				widx = caf_pkg::word_idx(addr_in, caf_pkg::MASK_BASE);
				d.rdata[caf_pkg::ID_W-1:0] = q.mask[widx[1:0]];
			end else if (caf_pkg::word_hit(addr_in, caf_pkg::FID_BASE,
			                               caf_pkg::NUM_FILTERS)) begin
				widx = caf_pkg::word_idx(addr_in, caf_pkg::FID_BASE);
				d.rdata[caf_pkg::ID_W-1:0] = q.fid[widx[caf_pkg::IDX_W-1:0]];
			end else if (addr_in == caf_pkg::STATUS_ADDR) begin
				d.rdata[caf_pkg::ST_FIFO_LO +: caf_pkg::IDX_W] = q.hit_fifo;
				d.rdata[caf_pkg::ST_FILT_LO +: caf_pkg::IDX_W] = q.hit_filter;
				d.rdata[caf_pkg::ST_SEEN_BIT]                  = q.seen;
				d.rdata[caf_pkg::ST_COUNT_LO +: 16]            = q.hit_count;
			end
		end

		// Store request one cycle after the identifier
		d.hit = rx_valid_in && m_hit;
		if (rx_valid_in && m_hit) begin
			d.hit_filter = m_filter;
			d.hit_fifo   = m_fifo;
			d.seen       = 1'b1;
			d.hit_count  = q.hit_count + 16'h0001;
		end

		for (int i = 0; i < caf_pkg::NUM_FILTERS; i++) begin
			d.en[i] = d.ctl[i][caf_pkg::EN_BIT];
		end

		if (!resetn_in) begin
			d      = '0;
			d.ctl  = {caf_pkg::NUM_FILTERS{caf_pkg::CTL_BYTE_RESET}};
			d.mask = {caf_pkg::NUM_MASKS{caf_pkg::MASK_RESET}};
			d.fid  = {caf_pkg::NUM_FILTERS{caf_pkg::FID_RESET}};
		end
	end

	always_ff @(posedge mclk_in) begin
		q <= d;
	end

	assign rdata_out         = q.rdata;
	assign store_valid_out   = q.hit;
	assign store_fifo_out    = q.hit_fifo;
	assign store_filter_out  = q.hit_filter;
	assign filter_enable_out = q.en;

endmodule

// file: testbench/caf_filter_config_properties.sv
`timescale 1ns/1ps
module caf_checker (
	// Clock and reset
	input wire logic                             mclk_in,
	input wire logic                             resetn_in,
	// Register port
	input wire logic [caf_pkg::ADDR_W-1:0]       addr_in,
	input wire logic [caf_pkg::DATA_W-1:0]       wdata_in,
	input wire logic                             wr_in,
	input wire logic                             rd_in,
	input wire logic [caf_pkg::DATA_W-1:0]       rdata_out,
	// Match path
	input wire logic                             rx_valid_in,
	input wire logic                             store_valid_out,
	input wire logic [caf_pkg::IDX_W-1:0]        store_fifo_out,
	input wire logic [caf_pkg::IDX_W-1:0]        store_filter_out,
	input wire logic [caf_pkg::NUM_FILTERS-1:0]  filter_enable_out
);
	logic [3:0]  en_bits;
	logic [15:0] en_prev_q;
	assign en_bits = {wdata_in[31], wdata_in[23], wdata_in[15], wdata_in[7]};
	always_ff @(posedge mclk_in) begin
		en_prev_q <= filter_enable_out;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	rdata_quiet_a: assert property (
		$past(resetn_in) && !$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside its cycle");
	lane_enable_a: assert property ($past(resetn_in) && $past(wr_in) && $past(addr_in) == 8'h00
		|-> filter_enable_out[3:0] == $past(en_bits)) else $error("enable lanes of word 0");
	reg_group_a: assert property ($past(resetn_in) && $past(wr_in) && $past(addr_in) == 8'h08
		|-> filter_enable_out[11:8] == $past(en_bits)) else $error("enable lanes of word 2");
	hold_enables_a: assert property (
		$past(resetn_in) && !$past(wr_in) |-> $stable(filter_enable_out))
		else $error("enables moved without a write");
	hit_enabled_a: assert property (store_valid_out |-> en_prev_q[store_filter_out])
		else $error("hit on a disabled filter");
	store_cause_a: assert property (
		store_valid_out |-> $past(rx_valid_in) && $past(resetn_in))
		else $error("store without an identifier");
	store_hold_a: assert property ($past(resetn_in) && !store_valid_out
		|-> $stable(store_fifo_out) && $stable(store_filter_out)) else $error("target moved");
endmodule
bind caf_filter_config caf_checker chk (
	.mclk_in           (mclk_in),
	.resetn_in         (resetn_in),
	.addr_in           (addr_in),
	.wdata_in          (wdata_in),
	.wr_in             (wr_in),
	.rd_in             (rd_in),
	.rdata_out         (rdata_out),
	.rx_valid_in       (rx_valid_in),
	.store_valid_out   (store_valid_out),
	.store_fifo_out    (store_fifo_out),
	.store_filter_out  (store_filter_out),
	.filter_enable_out (filter_enable_out)
);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        mclk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        rx_valid_in = 1'b0;
	logic [10:0] rx_id_in = 11'h000;
	logic [31:0] rdata_out;
	logic        store_valid_out;
	logic [3:0]  store_fifo_out;
	logic [3:0]  store_filter_out;
	logic [15:0] filter_enable_out;
	logic [31:0] rq[$];
	logic [7:0]  sq[$];
	logic        rd_q = 1'b0;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	logic [31:0] w;
	logic [10:0] id;
	always #20 mclk_in = ~mclk_in;
	caf_filter_config uut (
		.mclk_in           (mclk_in),
		.resetn_in         (resetn_in),
		.addr_in           (addr_in),
		.wdata_in          (wdata_in),
		.wr_in             (wr_in),
		.rd_in             (rd_in),
		.rdata_out         (rdata_out),
		.rx_valid_in       (rx_valid_in),
		.rx_id_in          (rx_id_in),
		.store_valid_out   (store_valid_out),
		.store_fifo_out    (store_fifo_out),
		.store_filter_out  (store_filter_out),
		.filter_enable_out (filter_enable_out)
	);
	task automatic fail(input string m);
		failures++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic final_report();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Write, or read with expected data noted
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wr_in <= wr;
		rd_in <= !wr;
		addr_in <= a;
		wdata_in <= d;
		if (!wr) rq.push_back(d);
		@(posedge mclk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
	endtask
	task automatic send(input logic [10:0] i, input logic hit, input logic [7:0] e);
		@(posedge mclk_in);
		rx_valid_in <= 1'b1;
		rx_id_in <= i;
		if (hit) sq.push_back(e);
		@(posedge mclk_in);
		rx_valid_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		compares++;
		if (sq.size() != 0) fail("store missing");
	endtask
	always @(posedge mclk_in) begin
		rd_q <= rd_in;
		cycles++;
		if (cycles > 3000) begin
			fail("timeout");
			final_report();
		end else begin
			if (rd_q) begin
				compares++;
				if (rdata_out !== rq.pop_front()) fail("read data");
			end
			if (store_valid_out === 1'b1) begin
				compares++;
				if (sq.size() == 0) fail("store pulse");
				else if ({store_fifo_out, store_filter_out} !== sq.pop_front())
					fail("target");
			end
		end
	end
	initial begin
		w = $urandom(32'he0db759e);
		repeat (10) @(posedge mclk_in);
		resetn_in <= 1'b1;
		for (int k = 0; k < 4; k++) bus(1'b0, 8'(4 * k), 32'h0);
		bus(1'b1, 8'h64, 32'h1234_5678);
		bus(1'b0, 8'h64, 32'h0);
		for (int k = 0; k < 4; k++) begin
			w = $urandom() & 32'h6f6f6f6f;
			bus(1'b1, 8'(4 * k), w);
			bus(1'b0, 8'(4 * k), w);
		end
		bus(1'b1, 8'h08, 32'h0000_a300);
		bus(1'b1, 8'h08, 32'h0000_ce00);
		bus(1'b0, 8'h08, 32'h0000_a300);
		bus(1'b1, 8'h08, 32'h0000_4e00);
		bus(1'b0, 8'h08, 32'h0000_2300);
		bus(1'b1, 8'h08, 32'h0000_4e00);
		bus(1'b0, 8'h08, 32'h0000_4e00);
		for (int d = 0; d < 16; d++) begin
			id = 11'($urandom());
			bus(1'b1, 8'h00, 32'h0);
			for (int j = 0; j < 4; j++) bus(1'b1, 8'(16 + 4 * j), (j == d % 4) ? 32'h7f0 : 32'h7ff);
			bus(1'b1, 8'h20, {21'h0, id});
			bus(1'b1, 8'h00, {24'h0, 1'b1, 2'(d % 4), 5'(d)});
			send(id ^ 11'h005, 1'b1, {4'(d), 4'h0});
			send(id ^ 11'h400, 1'b0, 8'h00);
		end
		bus(1'b1, 8'h00, 32'h0);
		send(id, 1'b0, 8'h00);
		// Status: sixteen hits, seen, filter 0, FIFO 15
		bus(1'b0, 8'h60, 32'h0010_010f);
		// Mid-run reset clears setup and status
		bus(1'b1, 8'h00, 32'h0000_00ef);
		resetn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		resetn_in <= 1'b1;
		bus(1'b0, 8'h00, 32'h0);
		bus(1'b0, 8'h60, 32'h0);
		send(id ^ 11'h005, 1'b0, 8'h00);
		final_report();
	end
endmodule
